// ---- design/ief_consts.svh ----
`ifndef IEF_CONSTS_SVH
`define IEF_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IEF_OFS_ENABLE_LOW 8'h08
`define IEF_OFS_ENABLE_HIGH 8'h09
`define IEF_OFS_ERROR_FLAGS 8'h0a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IEF_RST_ENABLE_LOW 8'h00
`define IEF_RST_ENABLE_HIGH 8'h00
`define IEF_RST_ERROR_FLAGS 5'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IEF_BIT_PIN_INVERT 7
`define IEF_BIT_DRIVE_TYPE 7
`define IEF_BIT_ROUTE_ENABLE 6
`define IEF_BIT_NVM_ERR 7
`define IEF_BIT_WR_ERR 6
`define IEF_BIT_OVERFLOW 5
`define IEF_BIT_SHORT_FRAME 4
`define IEF_BIT_EMPTY_TX 3

// ----------------------------------------
// Transceiver state codes and frame limits
// ----------------------------------------
`define IEF_CS_RX_WAIT 3'h5
`define IEF_CS_WAIT_DATA 3'h6
`define IEF_CS_RECEIVING 3'h7
`define IEF_MIN_FRAME_BITS 16'h0004
`define IEF_EMD_MIN_BITS 16'h0018

`endif

// ---- design/ief_pkg.sv ----
package ief_pkg;

   // ----------------------------------------
   // Register access request
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ief_reg_req_t;

   // ----------------------------------------
   // Buffer and command events
   // ----------------------------------------
   typedef struct packed {
      logic host_write;
      logic full;
      logic empty;
      logic flush;
      logic tx_required;
      logic crc_phase;
      logic auth_active;
      logic cl_cmd_start;
      logic multi_frame_receive;
      logic err_flags_stored;
      logic nvm_cmd_done;
      logic nvm_cmd_fail;
   } ief_cmd_evt_t;

   // ----------------------------------------
   // Receive path events
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] com_state;
      logic receive_cmd_start;
      logic wait_data_entry;
      logic sof_valid;
      logic frame_end;
      logic emd_suppress;
      logic [15:0] bit_count;
   } ief_rx_evt_t;

endpackage

// ---- design/ief_irq_enable_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ief_consts.svh"

module ief_irq_enable_flags #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire ief_pkg::ief_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [6:0] low_req_flags,
   input wire logic [5:0] high_req_flags,
   input wire ief_pkg::ief_cmd_evt_t cmd_evt,
   input wire ief_pkg::ief_rx_evt_t rx_evt,
   input wire logic [2:0] neighbour_err_flags,
   output logic any_request_flag,
   output logic error_request_flag,
   output logic buffer_write_accept,
   output logic frame_drop,
   output logic receive_done_event,
   output logic receive_decoder_keep,
   output logic int_pin_o,
   output logic int_pin_oe
);
   import ief_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] enable_low_q;
   logic [7:0] enable_high_q;
   logic [4:0] err_q;
   logic [4:0] err_d;
   logic [12:0] gated;
   logic global_d;
   logic pin_val;
   logic in_rx_state;
   logic wr_illegal;
   logic short_bits;
   logic short_frame;
   logic wr_attempt;
   logic [CNT_W-1:0] frame_bits;

   // Frame shorter than a limit; also used for the emd 24-bit limit
   function automatic logic below(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
      below = cnt < lim;
   endfunction

   // ----------------------------------------
   // Enable registers
   // ----------------------------------------
   // Plain read/write storage, steering the gating below
   // Writes to the error offset fall through; those bits are hardware owned
   always_ff @(posedge clock) begin
      if (srst) begin
         enable_low_q <= `IEF_RST_ENABLE_LOW;
         enable_high_q <= `IEF_RST_ENABLE_HIGH;
      end else if (ce && reg_req.wr) begin
         if (reg_req.addr == `IEF_OFS_ENABLE_LOW) begin
            enable_low_q <= reg_req.wdata;
         end
         if (reg_req.addr == `IEF_OFS_ENABLE_HIGH) begin
            enable_high_q <= reg_req.wdata;
         end
      end
   end

   // ----------------------------------------
   // Request gating and pin
   // ----------------------------------------
   // Low enables cover bits 6..0, high enables cover card detect and timers
   assign gated[6:0] = low_req_flags & enable_low_q[6:0];
   assign gated[7] = high_req_flags[5] & enable_high_q[5];
   assign gated[12:8] = high_req_flags[4:0] & enable_high_q[4:0];
   assign global_d = |gated;
   // Pin derives from the same term as the flag so both move together while route enable is set
   assign pin_val = (global_d & enable_high_q[`IEF_BIT_ROUTE_ENABLE])
      ^ enable_low_q[`IEF_BIT_PIN_INVERT];

   // Flag and pin drive registered together; open drain needs the pull-up for high
   always_ff @(posedge clock) begin
      if (srst) begin
         any_request_flag <= 1'b0;
         int_pin_o <= 1'b0;
         int_pin_oe <= 1'b0;
      end else if (ce) begin
         any_request_flag <= global_d;
         if (enable_high_q[`IEF_BIT_DRIVE_TYPE]) begin
            int_pin_o <= pin_val;
            int_pin_oe <= 1'b1;
         end else begin
            // Open drain only pulls low; a high level is left to the pull-up
            int_pin_o <= 1'b0;
            int_pin_oe <= ~pin_val;
         end
      end
   end

   // ----------------------------------------
   // Error flag conditions
   // ----------------------------------------
   // Receive-type states flag host writes as write errors but do not refuse them; the 24-bit limit only counts under emd
   assign in_rx_state = (rx_evt.com_state == `IEF_CS_RX_WAIT) ||
      (rx_evt.com_state == `IEF_CS_WAIT_DATA) || (rx_evt.com_state == `IEF_CS_RECEIVING);
   assign wr_attempt = cmd_evt.host_write;
   assign wr_illegal = wr_attempt && (cmd_evt.crc_phase || in_rx_state || cmd_evt.auth_active);
   // Count width is a parameter while the event carries sixteen bits
   assign frame_bits = CNT_W'(rx_evt.bit_count);
   assign short_bits = below(frame_bits, CNT_W'(`IEF_MIN_FRAME_BITS));
   assign short_frame = short_bits ||
      (rx_evt.emd_suppress && below(frame_bits, CNT_W'(`IEF_EMD_MIN_BITS)));

   // Sets are applied after clears so a same-cycle event is never lost
   always_comb begin
      err_d = err_q;
      if (cmd_evt.nvm_cmd_done) begin
         err_d[`IEF_BIT_NVM_ERR - 3] = cmd_evt.nvm_cmd_fail;
      end
      if (cmd_evt.cl_cmd_start || (cmd_evt.multi_frame_receive && cmd_evt.err_flags_stored)) begin
         err_d[`IEF_BIT_WR_ERR - 3] = 1'b0;
      end
      if (cmd_evt.flush) begin
         err_d[`IEF_BIT_OVERFLOW - 3] = 1'b0;
      end
      if (rx_evt.receive_cmd_start || rx_evt.wait_data_entry) begin
         err_d[`IEF_BIT_SHORT_FRAME - 3] = 1'b0;
      end
      if (cmd_evt.cl_cmd_start) begin
         err_d[`IEF_BIT_EMPTY_TX - 3] = 1'b0;
      end
      if (wr_illegal) begin
         err_d[`IEF_BIT_WR_ERR - 3] = 1'b1;
      end
      if (wr_attempt && cmd_evt.full) begin
         err_d[`IEF_BIT_OVERFLOW - 3] = 1'b1;
      end
      if (rx_evt.frame_end && rx_evt.sof_valid && short_bits) begin
         err_d[`IEF_BIT_SHORT_FRAME - 3] = 1'b1;
      end
      if (cmd_evt.tx_required && cmd_evt.empty) begin
         err_d[`IEF_BIT_EMPTY_TX - 3] = 1'b1;
      end
   end

   // Error flag storage, frozen with the rest while ce is low
   always_ff @(posedge clock) begin
      if (srst) begin
         err_q <= `IEF_RST_ERROR_FLAGS;
      end else if (ce) begin
         err_q <= err_d;
      end
   end

   // ----------------------------------------
   // Event outputs
   // ----------------------------------------
   // Combined error covers write, overflow, protocol, empty and integrity
   always_ff @(posedge clock) begin
      if (srst) begin
         error_request_flag <= 1'b0;
         buffer_write_accept <= 1'b0;
         frame_drop <= 1'b0;
         receive_done_event <= 1'b0;
         receive_decoder_keep <= 1'b0;
      end else if (ce) begin
         error_request_flag <= err_d[`IEF_BIT_WR_ERR - 3] | err_d[`IEF_BIT_OVERFLOW - 3] |
            neighbour_err_flags[1] | err_d[`IEF_BIT_EMPTY_TX - 3] | neighbour_err_flags[0];
         // Writes are refused while the overflow flag stands
         buffer_write_accept <= wr_attempt && !cmd_evt.full &&
            !err_q[`IEF_BIT_OVERFLOW - 3];
         // Short frames with a valid start of frame never raise the receive request, so the host is not woken
         frame_drop <= rx_evt.frame_end && rx_evt.sof_valid && short_frame;
         receive_done_event <= rx_evt.frame_end && !(rx_evt.sof_valid && short_frame);
         receive_decoder_keep <= rx_evt.frame_end && rx_evt.sof_valid && short_frame;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Unmapped offsets read as zero
   // Bits 2..0 of the error offset come live from the neighbouring checks
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd) begin
            case (reg_req.addr)
               `IEF_OFS_ENABLE_LOW: reg_rdata <= enable_low_q;
               `IEF_OFS_ENABLE_HIGH: reg_rdata <= enable_high_q;
               `IEF_OFS_ERROR_FLAGS: reg_rdata <= {err_q, neighbour_err_flags};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ---- tb/ief_chk_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module ief_chk (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire ief_pkg::ief_cmd_evt_t cmd_evt,
   input wire ief_pkg::ief_rx_evt_t rx_evt,
   input wire logic [6:0] low_req_flags,
   input wire logic [5:0] high_req_flags,
   input wire logic [2:0] neighbour_err_flags,
   input wire logic any_request_flag,
   input wire logic error_request_flag,
   input wire logic buffer_write_accept,
   input wire logic frame_drop,
   input wire logic receive_done_event,
   input wire logic receive_decoder_keep,
   input wire logic int_pin_o,
   input wire logic int_pin_oe
);
   import ief_pkg::*;
   logic sh;
   // Short frame seen this cycle
   assign sh = rx_evt.frame_end & rx_evt.sof_valid & (rx_evt.bit_count < 16'h0004);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_overflow_refuse: assert property (ce && cmd_evt.host_write && cmd_evt.full |=> !buffer_write_accept && error_request_flag) else $error("full write taken");
   a_accept_cause: assert property ($rose(buffer_write_accept) |-> $past(cmd_evt.host_write && ce)) else $error("accept without write");
   a_short_drop: assert property (ce && sh |=> frame_drop && !receive_done_event) else $error("short frame kept");
   a_drop_keeps: assert property (frame_drop |-> receive_decoder_keep) else $error("decoder not kept");
   a_good_frame: assert property (ce && rx_evt.frame_end && rx_evt.sof_valid && !rx_evt.emd_suppress && !sh |=> receive_done_event) else $error("frame lost");
   a_open_drain: assert property (!int_pin_oe |-> !int_pin_o) else $error("released pin driven high");
   a_quiet_global: assert property (ce && low_req_flags == 7'h00 && high_req_flags == 6'h00 |=> !any_request_flag) else $error("global without request");
   a_error_sum: assert property (ce && neighbour_err_flags[1:0] != 2'h0 |=> error_request_flag) else $error("error request missing");
   a_empty_send: assert property (ce && cmd_evt.tx_required && cmd_evt.empty |=> error_request_flag) else $error("empty send missed");
   cover property (frame_drop);
   cover property (any_request_flag && int_pin_oe);
   cover property (buffer_write_accept);
endmodule
bind ief_irq_enable_flags ief_chk ief_chk_i (.clock, .srst, .ce, .cmd_evt, .rx_evt, .low_req_flags, .high_req_flags,
   .neighbour_err_flags, .any_request_flag, .error_request_flag, .buffer_write_accept, .frame_drop,
   .receive_done_event, .receive_decoder_keep, .int_pin_o, .int_pin_oe);
`default_nettype wire

// ---- tb/ief_host_pin.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the request line, pulled up while released
module ief_host_pin (
   input wire logic int_pin_o,
   input wire logic int_pin_oe,
   output logic pin_level
);
   assign pin_level = int_pin_oe ? int_pin_o : 1'b1;
endmodule
`default_nettype wire

// ---- tb/test_irq_enable_and_error_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_irq_enable_and_error_flags;
   import ief_pkg::*;
   logic clock = 0, srst = 1, ce = 1;
   ief_reg_req_t reg_req = '0;
   ief_cmd_evt_t cmd_evt = '0;
   ief_rx_evt_t rx_evt = '0;
   logic [6:0] low_req_flags = '0;
   logic [5:0] high_req_flags = '0;
   logic [2:0] neighbour_err_flags = '0;
   logic [7:0] reg_rdata;
   logic reg_rvalid, any_request_flag, error_request_flag, buffer_write_accept, frame_drop;
   logic receive_done_event, receive_decoder_keep, int_pin_o, int_pin_oe, pin_level;
   logic [12:0] m;
   int n_fail = 0, n_tests = 0;
   // ----------------------------------------
   // Clock, design and host pin
   // ----------------------------------------
   initial forever #5 clock = ~clock;
   ief_irq_enable_flags ief_irq_enable_flags_i (.clock, .srst, .ce, .reg_req, .reg_rdata, .reg_rvalid, .low_req_flags,
      .high_req_flags, .cmd_evt, .rx_evt, .neighbour_err_flags, .any_request_flag, .error_request_flag,
      .buffer_write_accept, .frame_drop, .receive_done_event, .receive_decoder_keep, .int_pin_o, .int_pin_oe);
   ief_host_pin ief_host_pin_i (.int_pin_o, .int_pin_oe, .pin_level);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report();
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle strobe; answer lands after the sampling edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_req <= '{wr, ~wr, a, d};
      @(posedge clock);
      reg_req <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk("reg", exp, reg_rvalid ? reg_rdata : 8'hxx);
   endtask
   task automatic ev(input ief_cmd_evt_t c, input ief_rx_evt_t r);
      @(posedge clock);
      cmd_evt <= c;
      rx_evt <= r;
      @(posedge clock);
      cmd_evt <= '0;
      rx_evt <= '0;
      #1;
   endtask
   // Pin level the host sees equals (global and route) xor invert
   task automatic lvl(input logic [7:0] el, eh, input logic [6:0] lf, input logic [5:0] hf, input logic a);
      logic p;
      p = (a & eh[6]) ^ el[7];
      bus(1'b1, 8'h08, el);
      bus(1'b1, 8'h09, eh);
      @(posedge clock);
      low_req_flags <= lf;
      high_req_flags <= hf;
      repeat (2) @(posedge clock);
      #1;
      chk("irq", {6'h0, a, p}, {6'h0, any_request_flag, pin_level});
      chk("pin", {6'h0, eh[7] & p, eh[7] | ~p}, {6'h0, int_pin_o, int_pin_oe});
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      rd(8'h0f, 8'h00);
      bus(1'b1, 8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
      for (int i = 0; i < 13; i++) begin
         m = 13'h1 << i;
         lvl({i[1], m[6:0]}, {i[0], i[2], m[12:7]}, m[6:0], m[12:7], 1'b1);
         lvl({i[1], m[6:0]}, {i[0], 1'b1, m[12:7]}, ~m[6:0], ~m[12:7], 1'b0);
      end
      for (int i = 0; i < 5; i++) begin
         ev(i == 0 ? 12'h840 : i == 1 ? 12'h820 : 12'h800, {3'(i + 3), 21'h0});
         rd(8'h0a, 8'h40);
         ev(i[0] ? 12'h00c : 12'h010, '0);
         rd(8'h0a, 8'h00);
      end
      ev(12'hc00, '0);
      chk("ovf", 8'h01, {6'h0, buffer_write_accept, error_request_flag});
      ev(12'h800, '0);
      chk("ovf", 8'h01, {6'h0, buffer_write_accept, error_request_flag});
      rd(8'h0a, 8'h20);
      ev(12'h100, '0);
      ev(12'h800, '0);
      chk("ovf", 8'h02, {6'h0, buffer_write_accept, error_request_flag});
      ev(12'h280, '0);
      rd(8'h0a, 8'h08);
      ev(12'h010, '0);
      ev(12'h003, '0);
      rd(8'h0a, 8'h80);
      ev(12'h002, '0);
      rd(8'h0a, 8'h00);
      for (int i = 0; i < 2; i++) begin
         ev('0, 24'h060003);
         chk("frame", 8'h03, {5'h0, receive_done_event, frame_drop, receive_decoder_keep});
         rd(8'h0a, 8'h10);
         ev('0, i ? 24'h080000 : 24'h100000);
         rd(8'h0a, 8'h00);
      end
      ev('0, 24'h070010);
      chk("frame", 8'h03, {5'h0, receive_done_event, frame_drop, receive_decoder_keep});
      ev('0, 24'h060020);
      chk("frame", 8'h04, {5'h0, receive_done_event, frame_drop, receive_decoder_keep});
      @(posedge clock);
      neighbour_err_flags <= 3'h5;
      rd(8'h0a, 8'h05);
      chk("err", 8'h01, {7'h0, error_request_flag});
      // Low clock enable freezes the flags: an empty send must not land
      @(posedge clock);
      ce <= 1'b0;
      ev(12'h280, '0);
      @(posedge clock);
      ce <= 1'b1;
      rd(8'h0a, 8'h05);
      final_report();
   end
   // Hang guard
   initial begin
      #200000;
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
